/* dcs_pkg.sv */
// package for the dma channel source step and request select block
package dcs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SRC = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // control field positions
    localparam int SM_LO = 12;
    localparam int SM_HI = 13;
    localparam int RS_LO = 8;
    localparam int RS_HI = 11;
    localparam int TS_LO = 3;
    localparam int TS_HI = 4;
    localparam int RSV7 = 7;
    localparam logic [1:0] SM_RESET = 2'h0;
    localparam logic [3:0] RS_RESET = 4'h0;
    localparam logic [1:0] TS_RESET = 2'h0;
    localparam logic [31:0] ADDR_RESET = 32'h0;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SM_FIXED = 2'h0;
    localparam logic [1:0] SM_INC = 2'h1;
    localparam logic [1:0] SM_DEC = 2'h2;
    localparam logic [1:0] TS_BYTE = 2'h0;
    localparam logic [1:0] TS_WORD = 2'h1;
    localparam logic [1:0] TS_LONG = 2'h2;
    localparam logic [31:0] STEP_1 = 32'h1;
    localparam logic [31:0] STEP_2 = 32'h2;
    localparam logic [31:0] STEP_4 = 32'h4;
    localparam logic [31:0] STEP_0 = 32'h0;
    localparam logic [3:0] RS_EXT_DUAL = 4'h0;
    localparam logic [3:0] RS_BAD1 = 4'h1;
    localparam logic [3:0] RS_EXT_S_OUT = 4'h2;
    localparam logic [3:0] RS_EXT_S_IN = 4'h3;
    localparam logic [3:0] RS_AUTO = 4'h4;
    localparam logic [3:0] RS_BAD5 = 4'h5;
    localparam logic [3:0] RS_TMR0 = 4'h6;
    localparam logic [3:0] RS_TMR4 = 4'hA;
    localparam logic [3:0] RS_ADC = 4'hB;
    localparam logic [3:0] RS_SER0_TX = 4'hC;
    localparam logic [3:0] RS_SER0_RX = 4'hD;
    localparam logic [3:0] RS_SER1_TX = 4'hE;
    localparam logic [3:0] RS_SER1_RX = 4'hF;
    localparam int NUM_PERIPH = 10;

    // request-source classification
    typedef enum logic [2:0] {
        DCS_SRC_NONE = 3'b000,
        DCS_SRC_EXT_DUAL = 3'b001,
        DCS_SRC_EXT_OUT = 3'b010,
        DCS_SRC_EXT_IN = 3'b011,
        DCS_SRC_AUTO = 3'b100,
        DCS_SRC_PERIPH = 3'b101
    } dcs_src_kind_t;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dcs_bus_req_t;

    // peripheral request lines
    typedef struct packed {
        logic timer0_compare_a_req;
        logic timer1_compare_a_req;
        logic timer2_compare_a_req;
        logic timer3_compare_a_req;
        logic timer4_compare_a_req;
        logic converter1_done_req;
        logic serial0_tx_empty_req;
        logic serial0_rx_full_req;
        logic serial1_tx_empty_req;
        logic serial1_rx_full_req;
    } dcs_periph_req_t;
endpackage

/* dcs_channel.sv */
// one dma channel: source address stepping and request source select
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: step field 00 keeps the source address, 01 increments it, 11 is not to be used.
// R2: increment adds 1, 2 or 4 for byte, 16-bit and 32-bit transfers.
// R3: step field 10 subtracts 1, 2 or 4 for byte, 16-bit and 32-bit transfers.
// R4: the step field is ignored for single address transfers from the device inward.
// R5: software loads the channel 3 pointer with the location holding the data address.
// R6: channel 3 indirect mode steps the pointer by 4 or 0 whatever the size; the code also subtracts 4 when the step field is 10.
// R7: request code 0000 is external dual, 0100 is auto, 0001 and 0101 are prohibited.
// R8: code 0010 is external single outward, 0011 external single inward.
// R9: codes 0110-1010 pick timers 0-4, 1011 the converter, 1100-1111 serial tx/rx.
// R10: external request codes are honoured only on channels 0 and 1.
// R11: channels 2 and 3 have no programmable request source selection.
// R12: control bit 7 always reads 0 and is written 0.
// R13: size field 00 byte, 01 16-bit, 10 32-bit, 11 prohibited; it sets the step.
// R14: step and request fields reset to zero.
// R15: the source address updates once per completed transfer.
module dcs_channel #(
    parameter int CHANNEL = 0
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // register port
    input wire dcs_pkg::dcs_bus_req_t bus_in,
    output logic [31:0] rdata_out,
    // transfer side
    input wire logic xfer_done_in,
    input wire logic indirect_in,
    input wire logic ext_req_pin_in,
    input wire dcs_pkg::dcs_periph_req_t periph_in,
    // results
    output logic [31:0] src_addr_out,
    output logic xfer_req_out,
    output logic single_addr_out,
    output logic [2:0] src_kind_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // size to step amount
    function automatic logic [31:0] size_step(input logic [1:0] ts);
        case (ts)
            dcs_pkg::TS_BYTE: size_step = dcs_pkg::STEP_1;
            dcs_pkg::TS_WORD: size_step = dcs_pkg::STEP_2;
            dcs_pkg::TS_LONG: size_step = dcs_pkg::STEP_4;
            default: size_step = dcs_pkg::STEP_0;
        endcase
    endfunction

    // classify a request code for this channel
    function automatic dcs_pkg::dcs_src_kind_t classify(input logic [3:0] rs);
        if (CHANNEL >= 2) begin
            classify = dcs_pkg::DCS_SRC_NONE; // R11
        end else begin
            case (rs)
                dcs_pkg::RS_EXT_DUAL: classify = dcs_pkg::DCS_SRC_EXT_DUAL; // R7
                dcs_pkg::RS_EXT_S_OUT: classify = dcs_pkg::DCS_SRC_EXT_OUT; // R8
                dcs_pkg::RS_EXT_S_IN: classify = dcs_pkg::DCS_SRC_EXT_IN; // R8
                dcs_pkg::RS_AUTO: classify = dcs_pkg::DCS_SRC_AUTO; // R7
                dcs_pkg::RS_BAD1, dcs_pkg::RS_BAD5: classify = dcs_pkg::DCS_SRC_NONE;
                default: classify = dcs_pkg::DCS_SRC_PERIPH; // R9
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic ext_meta_q;
    logic ext_sync_q;
    // first stage read only by the second
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_req_pin_in;
            ext_sync_q <= ext_meta_q;
        end
    end

    // ------------------------------------------------------------
    // control and address registers
    // ------------------------------------------------------------
    logic [1:0] sm_q, sm_d;
    logic [3:0] rs_q, rs_d;
    logic [1:0] ts_q, ts_d;
    logic [31:0] addr_q, addr_d;
    logic [31:0] step;
    logic step_ignored;
    dcs_pkg::dcs_src_kind_t kind;

    assign kind = classify(rs_q);
    // inward single-address moves have no source address in memory
    assign step_ignored = (kind == dcs_pkg::DCS_SRC_EXT_IN); // R4

    // next control state and next source address
    always_comb begin
        sm_d = sm_q;
        rs_d = rs_q;
        ts_d = ts_q;
        addr_d = addr_q;
        step = (CHANNEL == 3 && indirect_in) ? dcs_pkg::STEP_4 // R6
                                             : size_step(ts_q); // R2 R13
        if (xfer_done_in && !step_ignored) begin // R15
            case (sm_q)
                dcs_pkg::SM_INC: addr_d = addr_q + step; // R1 R2
                dcs_pkg::SM_DEC: addr_d = addr_q - step; // R3
                default: addr_d = addr_q; // R1
            endcase
        end
        // a software write to the pointer wins over a step
        if (bus_in.wr && bus_in.addr == dcs_pkg::ADDR_SRC) begin
            addr_d = bus_in.wdata; // R5
        end
        if (bus_in.wr && bus_in.addr == dcs_pkg::ADDR_CTRL) begin
            sm_d = bus_in.wdata[dcs_pkg::SM_HI:dcs_pkg::SM_LO];
            ts_d = bus_in.wdata[dcs_pkg::TS_HI:dcs_pkg::TS_LO];
            // no selector is held on channels 2 and 3
            rs_d = (CHANNEL >= 2) ? dcs_pkg::RS_RESET
                                  : bus_in.wdata[dcs_pkg::RS_HI:dcs_pkg::RS_LO]; // R11
        end
    end

    // register the control state
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sm_q <= dcs_pkg::SM_RESET; // R14
            rs_q <= dcs_pkg::RS_RESET; // R14
            ts_q <= dcs_pkg::TS_RESET;
            addr_q <= dcs_pkg::ADDR_RESET;
        end else begin
            sm_q <= sm_d;
            rs_q <= rs_d;
            ts_q <= ts_d;
            addr_q <= addr_d;
        end
    end

    // ------------------------------------------------------------
    // request selection
    // ------------------------------------------------------------
    logic req_d, req_q;
    logic [dcs_pkg::NUM_PERIPH-1:0] plines;
    logic [3:0] pidx;

    assign plines = periph_in;
    // bit 9 of the packed struct is timer 0, down to serial 1 rx at bit 0
    assign pidx = 4'(dcs_pkg::NUM_PERIPH - 1) - (rs_q - dcs_pkg::RS_TMR0);

    // pick the active request line
    always_comb begin
        case (kind)
            dcs_pkg::DCS_SRC_EXT_DUAL,
            dcs_pkg::DCS_SRC_EXT_OUT,
            dcs_pkg::DCS_SRC_EXT_IN: req_d = ext_sync_q; // R10
            dcs_pkg::DCS_SRC_AUTO: req_d = 1'b1; // R7
            dcs_pkg::DCS_SRC_PERIPH: req_d = plines[pidx]; // R9
            default: req_d = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // outputs and read data
    // ------------------------------------------------------------
    logic [31:0] rdata_d, rdata_q;
    logic single_d, single_q;
    logic [2:0] kind_q;

    // read mux; bit 7 and unused bits stay zero
    always_comb begin
        rdata_d = 32'h0;
        single_d = (kind == dcs_pkg::DCS_SRC_EXT_OUT) ||
                   (kind == dcs_pkg::DCS_SRC_EXT_IN);
        if (bus_in.rd) begin
            case (bus_in.addr)
                dcs_pkg::ADDR_CTRL: begin
                    rdata_d[dcs_pkg::SM_HI:dcs_pkg::SM_LO] = sm_q;
                    rdata_d[dcs_pkg::RS_HI:dcs_pkg::RS_LO] = rs_q;
                    rdata_d[dcs_pkg::TS_HI:dcs_pkg::TS_LO] = ts_q;
                    rdata_d[dcs_pkg::RSV7] = 1'b0; // R12
                end
                dcs_pkg::ADDR_SRC: rdata_d = addr_q;
                dcs_pkg::ADDR_STAT: rdata_d = {29'h0, kind};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // output flops
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= 32'h0;
            req_q <= 1'b0;
            single_q <= 1'b0;
            kind_q <= 3'h0;
        end else begin
            rdata_q <= rdata_d;
            req_q <= req_d;
            single_q <= single_d;
            kind_q <= kind;
        end
    end

    assign rdata_out = rdata_q;
    assign src_addr_out = addr_q;
    assign xfer_req_out = req_q;
    assign single_addr_out = single_q;
    assign src_kind_out = kind_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_fixed_hold;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (sm_q == dcs_pkg::SM_FIXED && !(bus_in.wr && bus_in.addr == dcs_pkg::ADDR_SRC))
        |=> $stable(addr_q);
    endproperty
    a_fixed_hold: assert property (p_fixed_hold) else $error("fixed address moved"); // R1

    property p_inc;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (xfer_done_in && sm_q == dcs_pkg::SM_INC && !step_ignored &&
         !(CHANNEL == 3 && indirect_in) && ts_q == dcs_pkg::TS_WORD &&
         !(bus_in.wr && bus_in.addr == dcs_pkg::ADDR_SRC))
        |=> addr_q == $past(addr_q) + dcs_pkg::STEP_2;
    endproperty
    a_inc: assert property (p_inc) else $error("word increment wrong"); // R2

    property p_dec;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (xfer_done_in && sm_q == dcs_pkg::SM_DEC && !step_ignored &&
         !(CHANNEL == 3 && indirect_in) && ts_q == dcs_pkg::TS_BYTE &&
         !(bus_in.wr && bus_in.addr == dcs_pkg::ADDR_SRC))
        |=> addr_q == $past(addr_q) - dcs_pkg::STEP_1;
    endproperty
    a_dec: assert property (p_dec) else $error("byte decrement wrong"); // R3

    property p_ignore;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (step_ignored && !(bus_in.wr && bus_in.addr == dcs_pkg::ADDR_SRC))
        |=> $stable(addr_q);
    endproperty
    a_ignore: assert property (p_ignore) else $error("inward step applied"); // R4

    property p_indirect;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (CHANNEL == 3 && indirect_in && xfer_done_in && sm_q == dcs_pkg::SM_INC &&
         !step_ignored && !(bus_in.wr && bus_in.addr == dcs_pkg::ADDR_SRC))
        |=> addr_q == $past(addr_q) + dcs_pkg::STEP_4;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect step not 4"); // R6

    property p_auto;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (rs_q == dcs_pkg::RS_AUTO && CHANNEL < 2) |=> xfer_req_out;
    endproperty
    a_auto: assert property (p_auto) else $error("auto request missing"); // R7

    property p_no_sel;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (CHANNEL >= 2) |-> (rs_q == dcs_pkg::RS_RESET && !xfer_req_out);
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("selector on channel 2/3"); // R11

    property p_rsv;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (bus_in.rd && bus_in.addr == dcs_pkg::ADDR_CTRL) |=> !rdata_out[dcs_pkg::RSV7];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read as one"); // R12

    property p_single_in;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (rs_q == dcs_pkg::RS_EXT_S_IN && CHANNEL < 2) |=> single_addr_out;
    endproperty
    a_single_in: assert property (p_single_in) else $error("single mode missing"); // R8

    c_inc: cover property (@(posedge mclk_in) xfer_done_in && sm_q == dcs_pkg::SM_INC);
    c_dec: cover property (@(posedge mclk_in) xfer_done_in && sm_q == dcs_pkg::SM_DEC);
    c_periph: cover property (@(posedge mclk_in) kind == dcs_pkg::DCS_SRC_PERIPH && req_d);
    c_ext: cover property (@(posedge mclk_in) kind == dcs_pkg::DCS_SRC_EXT_DUAL && ext_sync_q);
endmodule // dcs_channel
`default_nettype wire

/* dcs_req_partner.sv */
// partner model: on-chip request lines and the external request pin
`timescale 1ns/1ps
`default_nettype none
module dcs_req_partner (
    // clock
    input wire logic mclk_in,
    // scenario control
    input wire logic [3:0] code_in,
    input wire logic only_sel_in,
    // request lines
    output var dcs_pkg::dcs_periph_req_t periph_out,
    output logic ext_pin_out
);
    logic [9:0] lines_d;
    // line i serves code 6+i; timer0 sits in the top bit of the struct
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            lines_d[9-i] = only_sel_in == (code_in == 4'(6 + i));
        end
    end
    // flags move just after an edge, as a real peripheral's would
    always_ff @(posedge mclk_in) begin
        periph_out <= lines_d;
        ext_pin_out <= only_sel_in && (code_in inside {4'h0, 4'h2, 4'h3});
    end
endmodule // dcs_req_partner
`default_nettype wire

/* tb.sv */
// self-checking bench for source stepping and request select
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {logic [1:0] sm; logic [1:0] ts; logic ind;
        int stp; int stp3;} dcs_row_t;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    dcs_pkg::dcs_bus_req_t bus = '0;
    logic xd = 1'b0;
    logic ind = 1'b1;
    logic [3:0] code = 4'h0;
    logic only_sel = 1'b0;
    dcs_pkg::dcs_periph_req_t periph;
    logic pin, req0, req3, sgl0;
    logic [31:0] rd0, rd3, a0, a3, v, w;
    logic [2:0] kind0, kind3;
    int miscompares = 0;
    int n_compared = 0;
    dcs_row_t rows[10] = '{'{0, 0, 1, 0, 0}, '{1, 0, 1, 1, 4},
        '{1, 1, 1, 2, 4}, '{1, 2, 1, 4, 4}, '{2, 0, 1, -1, -4},
        '{2, 1, 1, -2, -4}, '{2, 2, 1, -4, -4}, '{0, 2, 1, 0, 0},
        '{3, 1, 1, 0, 0}, '{1, 0, 0, 1, 1}};
    // ------------------------------------------------------------
    // clock, partner and the two channels under test
    // ------------------------------------------------------------
    always #2 mclk_in = ~mclk_in;
    dcs_req_partner partner (.mclk_in(mclk_in), .code_in(code),
        .only_sel_in(only_sel), .periph_out(periph), .ext_pin_out(pin));
    dcs_channel #(.CHANNEL(0)) dut (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .bus_in(bus), .rdata_out(rd0),
        .xfer_done_in(xd), .indirect_in(ind), .ext_req_pin_in(pin),
        .periph_in(periph), .src_addr_out(a0), .xfer_req_out(req0),
        .single_addr_out(sgl0), .src_kind_out(kind0));
    // channel 3 shares the bus so every write reaches both
    dcs_channel #(.CHANNEL(3)) dut_ch3 (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .bus_in(bus), .rdata_out(rd3),
        .xfer_done_in(xd), .indirect_in(ind), .ext_req_pin_in(pin),
        .periph_in(periph), .src_addr_out(a3), .xfer_req_out(req3),
        .single_addr_out(), .src_kind_out(kind3));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus <= '0;
        #1;
        v = rd0;
        w = rd3;
    endtask
    task automatic xfer(input int n);
        @(posedge mclk_in);
        xd <= 1'b1;
        repeat (n) @(posedge mclk_in);
        xd <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] sm,
        input logic [3:0] rs, input logic [1:0] ts);
        ctl = '0;
        ctl[dcs_pkg::SM_HI:dcs_pkg::SM_LO] = sm;
        ctl[dcs_pkg::RS_HI:dcs_pkg::RS_LO] = rs;
        ctl[dcs_pkg::TS_HI:dcs_pkg::TS_LO] = ts;
        ctl[dcs_pkg::RSV7] = 1'b0;
    endfunction
    function automatic logic [2:0] kexp(input int c);
        if (c >= 6) return 3'h5;
        return (c == 1 || c == 5) ? 3'h0 : (c == 0 ? 3'h1 : 3'(c));
    endfunction
    // watchdog: a hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge mclk_in);
        miscompares++;
        end_sim();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        check("kind reset", kind0, dcs_pkg::DCS_SRC_EXT_DUAL);
        check("addr reset", a0, 32'h0);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC);
        check("unmapped", v, 32'h0);
        rd(dcs_pkg::ADDR_CTRL);
        check("ctrl reset", {v[13:12], v[11:8]}, 6'h00);
        // stepping table: two back-to-back transfers per row
        foreach (rows[i]) begin
            @(posedge mclk_in);
            ind <= rows[i].ind;
            wr(dcs_pkg::ADDR_CTRL, ctl(rows[i].sm, dcs_pkg::RS_AUTO,
                rows[i].ts));
            wr(dcs_pkg::ADDR_SRC, 32'h1000);
            xfer(2);
            rd(dcs_pkg::ADDR_SRC);
            check("src ch0", v, 32'h1000 + 2 * rows[i].stp);
            check("src ch3", w, 32'h1000 + 2 * rows[i].stp3);
            check("src port", a0, 32'h1000 + 2 * rows[i].stp);
        end
        // single address inward: step ignored; reserved bit reads 0
        @(posedge mclk_in);
        ind <= 1'b1;
        wr(dcs_pkg::ADDR_CTRL, ctl(dcs_pkg::SM_INC, dcs_pkg::RS_EXT_S_IN,
            dcs_pkg::TS_LONG));
        wr(dcs_pkg::ADDR_SRC, 32'h2000);
        xfer(1);
        rd(dcs_pkg::ADDR_CTRL);
        check("bit7", {v[7], w[7]}, 2'h0);
        check("fields", {v[13:12], v[11:8], v[4:3]}, {dcs_pkg::SM_INC,
            dcs_pkg::RS_EXT_S_IN, dcs_pkg::TS_LONG});
        check("ch3 select", w[11:8], 4'h0);
        rd(dcs_pkg::ADDR_SRC);
        check("src inward", v, 32'h2000);
        check("src ch3", w, 32'h2004);
        check("single", sgl0, 1'b1);
        // every request code, first with the wrong lines raised
        for (int c = 0; c < 16; c++) begin
            @(posedge mclk_in);
            code <= 4'(c);
            only_sel <= 1'b0;
            wr(dcs_pkg::ADDR_CTRL, ctl(dcs_pkg::SM_FIXED, 4'(c), 2'h0));
            repeat (5) @(posedge mclk_in);
            #1;
            check("req other", req0, c == 4);
            @(posedge mclk_in);
            only_sel <= 1'b1;
            repeat (5) @(posedge mclk_in);
            #1;
            check("req sel", req0, !(c inside {1, 5}));
            check("req ch3", req3, 1'b0);
            check("kind ch3", kind3, dcs_pkg::DCS_SRC_NONE);
            rd(dcs_pkg::ADDR_STAT);
            check("kind", v[2:0], kexp(c));
        end
        // reset again in mid-run
        @(posedge mclk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        rd(dcs_pkg::ADDR_CTRL);
        check("ctrl rerst", {v[13:12], v[11:8]}, 6'h00);
        check("addr rerst", a0, 32'h0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
